/* File: bench/mac_cpu_model.sv */
// Purpose: Core decode model that issues one accumulator op
// Assumes: One op per call, then one idle cycle
// Notes: Released buses show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module mac_cpu_model (
   input wire logic core_clk,
   output logic [15:0] bus_x,
   output logic [15:0] bus_y,
   output logic op_valid,
   output logic [10:0] op_ctrl
);
   initial begin
      bus_x = 16'h0000;
      bus_y = 16'h0000;
      op_valid = 1'b0;
      op_ctrl = 11'h000;
   end
   task automatic issue(input logic [15:0] x, input logic [15:0] y,
      input logic [10:0] c);
      @(posedge core_clk);
      bus_x <= x;
      bus_y <= y;
      op_ctrl <= c;
      op_valid <= 1'b1;
      @(posedge core_clk);
      op_valid <= 1'b0;
      bus_x <= ~x;
      bus_y <= ~y;
   endtask
endmodule
`default_nettype wire

/* File: bench/mac_multiply_accumulate_unit_tb.sv */
// Purpose: Self-checking bench for the accumulator datapath
// Assumes: Decode model issues ops; bench does writes and stores
// Notes: Row fields are x, y, op controls, expected accumulator
`timescale 1ns/1ps
`default_nettype none
module mac_multiply_accumulate_unit_tb;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [3:0] wr = 4'h0;
   logic [15:0] wd = 16'h0000;
   logic st_op = 1'b0;
   logic [1:0] st_sel = 2'h0;
   logic [2:0] ridx = 3'h0;
   wire logic [15:0] bx, by, hi, lo, stw, ctl, sd, trd;
   wire logic [10:0] oc;
   wire logic ov, sval;
   wire logic [39:0] acc = {stw[7:0], hi, lo};
   int err_count = 0;
   int checks_done = 0;
   logic [83:0] rows [9] = '{84'h0003_0004_3C0_000000000C,
      84'hFFFE_0005_3C8_0000000002, 84'h8000_0002_240_0000010000,
      84'h0000_0000_028_0000018000, 84'h1234_5678_060_0012345678,
      84'h4000_0001_070_0080000002, 84'h0000_0001_06A_FF7FFFFFFF,
      84'h0000_0000_00C_FFFFFF7FFF, 84'h0002_0055_5C1_00000000AA};
   logic [27:0] sts [6] = '{28'h01_3_7FFF, 28'hFF_3_8000, 28'h00_3_1234,
      28'h00_0_1234, 28'h00_1_5678, 28'h00_2_0000};
   always #10 core_clk = ~core_clk;
   mac_cpu_model u_mac_cpu_model (.core_clk(core_clk), .bus_x(bx),
      .bus_y(by), .op_valid(ov), .op_ctrl(oc));
   mac_unit u_mac_unit (.core_clk(core_clk), .sys_rst(sys_rst),
      .operand_bus_first(bx), .operand_bus_second(by), .op_valid(ov),
      .mul_x_sel(oc[10]), .mul_y_sel(oc[9]), .mul_x_signed(oc[8]),
      .mul_y_signed(oc[7]), .a_src_sel(oc[6:5]), .concat_shift(oc[4]),
      .b_use_acc(oc[3]), .b_shift_right(oc[2]), .b_invert(oc[1]),
      .multiply_with_move_op(oc[0]), .table_rd_idx(ridx),
      .control_wr(wr[0]), .control_wdata(wd), .status_wr(wr[1]),
      .status_wdata(wd), .acc_high_wr(wr[2]), .acc_low_wr(wr[3]),
      .acc_wdata(wd), .coproc_store_op(st_op), .store_sel(st_sel),
      .acc_high_word(hi), .acc_low_word(lo), .mac_status_word(stw),
      .mac_control_word(ctl), .store_data(sd), .store_valid(sval),
      .table_rd_data(trd));
   task automatic chk(input string n, input logic [39:0] s,
      input logic [39:0] e);
      checks_done++;
      if (s !== e) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic sw(input int k, input logic [15:0] d);
      @(posedge core_clk);
      wd <= d;
      wr <= 4'(1 << k);
      @(posedge core_clk);
      wr <= 4'h0;
      #1;
   endtask
   task automatic op(input logic [15:0] x, input logic [15:0] y,
      input logic [10:0] c);
      u_mac_cpu_model.issue(x, y, c);
      #1;
   endtask
   task automatic st(input logic [1:0] s, input logic [15:0] e);
      @(posedge core_clk);
      st_op <= 1'b1;
      st_sel <= s;
      @(posedge core_clk);
      st_op <= 1'b0;
      #1;
      chk("store valid", 40'(sval), 40'h1);
      chk("store data", 40'(sd), 40'(e));
   endtask
   task automatic do_reset();
      @(posedge core_clk);
      sys_rst <= 1'b1;
      repeat (3) @(posedge core_clk);
      sys_rst <= 1'b0;
      #1;
      chk("status", 40'(stw), 40'h0200);
      chk("control", 40'(ctl), 40'h0);
      chk("acc", acc, 40'h0);
      $display("test reset done");
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge core_clk);
      err_count++;
      report_and_stop();
   end
   initial begin
      do_reset();
      foreach (rows[i]) begin
         op(rows[i][83:68], rows[i][67:52], rows[i][50:40]);
         chk("acc row", acc, rows[i][39:0]);
      end
      repeat (2) @(posedge core_clk);
      #1;
      chk("table entry", 40'(trd), 40'h2);
      op(16'h0007, 16'h0001, 11'h5C1);
      chk("move product", acc, 40'h00_0000_0007);
      @(posedge core_clk);
      ridx <= 3'h1;
      repeat (2) @(posedge core_clk);
      #1;
      chk("table shifted", 40'(trd), 40'h2);
      $display("test rows done");
      sw(0, 16'h0200);
      op(16'h4000, 16'h4000, 11'h3C0);
      chk("shifted product", acc, 40'h00_2000_0000);
      sw(0, 16'h0400);
      sw(1, 16'h0000);
      sw(2, 16'h7FFF);
      sw(3, 16'hFFFF);
      op(16'h0000, 16'h0000, 11'h028);
      chk("sat pos", acc, 40'h00_7FFF_FFFF);
      chk("sat flag", 40'(stw[13]), 40'h1);
      op(16'h8000, 16'h0000, 11'h060);
      chk("sat flag held", 40'(stw[13]), 40'h1);
      op(16'h8000, 16'h0000, 11'h068);
      chk("sat neg", acc, 40'hFF_8000_0000);
      sw(1, 16'h0000);
      chk("sat flag clear", 40'(stw[13]), 40'h0);
      sw(0, 16'h0000);
      sw(1, 16'h007F);
      sw(2, 16'hFFFF);
      sw(3, 16'hFFFF);
      op(16'h0000, 16'h0000, 11'h028);
      chk("wrap acc", acc, 40'h80_0000_7FFF);
      op(16'h0000, 16'h0000, 11'h020);
      chk("ovf flag held", 40'(stw[11]), 40'h1);
      $display("test saturation done");
      sw(2, 16'h1234);
      sw(3, 16'h5678);
      foreach (sts[i]) begin
         sw(1, {8'h00, sts[i][27:20]});
         st(sts[i][17:16], sts[i][15:0]);
         chk("acc kept", acc, {sts[i][27:20], 32'h1234_5678});
      end
      $display("test store done");
      do_reset();
      report_and_stop();
   end
endmodule
`default_nettype wire

/* File: bench/mac_unit_properties.sv */
// Purpose: Port assertions for the accumulator datapath
// Assumes: A store uses the flags held before its edge
// Notes: Bound into every mac_unit
`timescale 1ns/1ps
`default_nettype none
module mac_unit_properties (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic op_valid,
   input wire logic status_wr,
   input wire logic acc_high_wr,
   input wire logic acc_low_wr,
   input wire logic coproc_store_op,
   input wire logic [1:0] store_sel,
   input wire logic [15:0] acc_high_word,
   input wire logic [15:0] mac_status_word,
   input wire logic [15:0] mac_control_word,
   input wire logic [15:0] store_data,
   input wire logic store_valid
);
   wire logic [8:0] top = {mac_status_word[7:0], acc_high_word[15]};
   wire logic ext = mac_status_word[mac_pkg::ST_E];
   wire logic neg = mac_status_word[mac_pkg::ST_N];
   wire logic lim = coproc_store_op && store_sel == mac_pkg::ST_LIMITED;
   wire logic hw = status_wr || acc_high_wr || acc_low_wr;
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   a_store_pulse: assert property (coproc_store_op |=> store_valid)
      else $error("store result not flagged");
   a_limit_pos: assert property (lim && ext && !neg |=> store_data == 16'h7FFF)
      else $error("positive limit wrong");
   a_limit_neg: assert property (lim && ext && neg |=> store_data == 16'h8000)
      else $error("negative limit wrong");
   a_limit_pass: assert property (lim && !ext |=> store_data == $past(acc_high_word))
      else $error("unlimited store altered");
   a_store_keeps: assert property (coproc_store_op && !op_valid && !hw
      |=> $stable(mac_status_word) && $stable(acc_high_word))
      else $error("store changed state");
   a_sat_sticky: assert property (mac_status_word[13] && !status_wr |=> mac_status_word[13])
      else $error("saturation flag dropped");
   a_ovf_sticky: assert property (mac_status_word[11] && !status_wr |=> mac_status_word[11])
      else $error("overflow flag dropped");
   a_ext_flag: assert property (ext == !(&top || ~|top))
      else $error("extension flag wrong");
   a_sat_bound: assert property (op_valid && mac_control_word[10] && !hw |=> !ext)
      else $error("saturated value too wide");
   a_reset_status: assert property ($fell(sys_rst) |-> mac_status_word == 16'h0200)
      else $error("status reset value wrong");
   c_limit_neg: cover property (lim && ext && neg);
   c_sat_op: cover property (op_valid && mac_control_word[10]);
   c_sat_flag: cover property ($rose(mac_status_word[13]));
endmodule
bind mac_unit mac_unit_properties u_mac_unit_properties (.core_clk, .sys_rst,
   .op_valid, .status_wr, .acc_high_wr, .acc_low_wr, .coproc_store_op,
   .store_sel, .acc_high_word, .mac_status_word, .mac_control_word,
   .store_data, .store_valid);
`default_nettype wire

/* File: pkg/mac_pkg.sv */
// Purpose: Shared constants for the multiply-accumulate datapath
// Assumes: 16-bit core, 40-bit accumulator
// Notes: Status and control bit positions are fixed here
package mac_pkg;
   localparam int WORD_W = 16;
   localparam int ACC_W = 40;
   localparam int TABLE_DEPTH = 8;
   localparam int TABLE_IDX_W = 3;
   // Status word fields
   localparam int ST_N = 8;
   localparam int ST_Z = 9;
   localparam int ST_E = 10;
   localparam int ST_SV = 11;
   localparam int ST_C = 12;
   localparam int ST_SL = 13;
   localparam logic [15:0] STATUS_RESET = 16'h0200;
   // Control word fields
   localparam int CW_MP = 9;
   localparam int CW_MS = 10;
   localparam logic [15:0] CONTROL_RESET = 16'h0000;
   localparam logic [15:0] ACC_WORD_RESET = 16'h0000;
   // A source select
   localparam logic [1:0] A_ZERO = 2'h0;
   localparam logic [1:0] A_ROUND = 2'h1;
   localparam logic [1:0] A_PRODUCT = 2'h2;
   localparam logic [1:0] A_CONCAT = 2'h3;
   localparam logic [39:0] ROUND_CONST = 40'h00_0000_8000;
   localparam logic [39:0] SAT_POS = 40'h00_7FFF_FFFF;
   localparam logic [39:0] SAT_NEG = 40'hFF_8000_0000;
   localparam logic [15:0] LIMIT_POS = 16'h7FFF;
   localparam logic [15:0] LIMIT_NEG = 16'h8000;
   // Store source select
   localparam logic [1:0] ST_HIGH = 2'h0;
   localparam logic [1:0] ST_LOW = 2'h1;
   localparam logic [1:0] ST_STATUS = 2'h2;
   localparam logic [1:0] ST_LIMITED = 2'h3;
endpackage

/* File: pkg/mac_table_if.sv */
// Purpose: Link between datapath and operand table
// Assumes: Single clock
// Notes: Read data is registered inside the table
`timescale 1ns/1ps
`default_nettype none
interface mac_table_if;
   logic shift_en;
   logic [15:0] shift_in;
   logic [2:0] rd_idx;
   logic [15:0] rd_data;
   modport dp (output shift_en, output shift_in, output rd_idx,
      input rd_data);
   modport mem (input shift_en, input shift_in, input rd_idx,
      output rd_data);
endinterface
`default_nettype wire

/* File: verilog/mac_table.sv */
// Purpose: Operand table that shifts by one entry on a move
// Assumes: Shift and read in the same cycle see the old contents
// Notes: Read data comes from a register
`timescale 1ns/1ps
`default_nettype none
module mac_table (
   input wire logic core_clk,
   input wire logic sys_rst,
   mac_table_if.mem tbl
);
   logic [15:0] entry [mac_pkg::TABLE_DEPTH];

   genvar i;
   generate
      for (i = 0; i < mac_pkg::TABLE_DEPTH; i++) begin : g_entry
         always_ff @(posedge core_clk or posedge sys_rst) begin
            if (sys_rst) begin
               entry[i] <= 16'h0000;
            end else if (tbl.shift_en) begin
               if (i == 0) begin
                  entry[i] <= tbl.shift_in;
               end else begin
                  entry[i] <= entry[(i == 0) ? 0 : i - 1];
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tbl.rd_data <= 16'h0000;
      end else begin
         tbl.rd_data <= entry[tbl.rd_idx];
      end
   end
endmodule
`default_nettype wire

/* File: verilog/mac_unit.sv */
// Purpose: Multiply-accumulate datapath with 40-bit accumulator
// Assumes: Decode drives op controls for one cycle per operation
// Notes: All outputs registered; software writes lose to hardware sets
//
// Summary of operation
// - 16x16 multiply, signed or unsigned, 32-bit product
// - Each operand picked from either bus
// - Product sign-extended, optional one-bit left shift
// - 40-bit adder; extension flag on 32-bit overflow
// - A source: zero, round, product, concatenation
// - Concatenation shifted left by instruction request
// - B source: zero or shifted/inverted accumulator
// - Zeroed input passes other; result to accumulator
// - Saturation enabled clamps to 32-bit extremes
// - Saturation sets sticky flag until cleared
// - 40-bit overflow sets sticky flag until cleared
// - Accumulator is high, low, extension byte
// - Limited store gives 7FFF or 8000 when extension flag set, else high word
// - Limited store changes no accumulator or flag
// - Multiply-with-move shifts operand table concurrently
// - Reset: status 0200h, control zero
// - Reset: accumulator words read zero
`timescale 1ns/1ps
`default_nettype none
module mac_unit (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [15:0] operand_bus_first,
   input wire logic [15:0] operand_bus_second,
   input wire logic op_valid,
   input wire logic mul_x_sel,
   input wire logic mul_y_sel,
   input wire logic mul_x_signed,
   input wire logic mul_y_signed,
   input wire logic [1:0] a_src_sel,
   input wire logic concat_shift,
   input wire logic b_use_acc,
   input wire logic b_shift_right,
   input wire logic b_invert,
   input wire logic multiply_with_move_op,
   input wire logic [2:0] table_rd_idx,
   input wire logic control_wr,
   input wire logic [15:0] control_wdata,
   input wire logic status_wr,
   input wire logic [15:0] status_wdata,
   input wire logic acc_high_wr,
   input wire logic acc_low_wr,
   input wire logic [15:0] acc_wdata,
   input wire logic coproc_store_op,
   input wire logic [1:0] store_sel,
   output logic [15:0] acc_high_word,
   output logic [15:0] acc_low_word,
   output logic [15:0] mac_status_word,
   output logic [15:0] mac_control_word,
   output logic [15:0] store_data,
   output logic store_valid,
   output logic [15:0] table_rd_data
);
   mac_table_if tbl ();

   mac_table u_table (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .tbl(tbl.mem)
   );

   assign tbl.shift_en = op_valid & multiply_with_move_op;
   assign tbl.shift_in = operand_bus_first;
   assign tbl.rd_idx = table_rd_idx;

   // Multiplier operands and sign handling
   wire [15:0] mul_x = mul_x_sel ? operand_bus_second
      : operand_bus_first;
   wire [15:0] mul_y = mul_y_sel ? operand_bus_second
      : operand_bus_first;
   wire signed [16:0] mul_x_ext = {mul_x_signed & mul_x[15], mul_x};
   wire signed [16:0] mul_y_ext = {mul_y_signed & mul_y[15], mul_y};
   wire signed [33:0] mul_full = mul_x_ext * mul_y_ext;
   wire [31:0] product = mul_full[31:0];
   wire prod_sign = mul_full[33];
   wire [39:0] product_ext = {{8{prod_sign}}, product};
   wire product_shift_bit = mac_control_word[mac_pkg::CW_MP];
   wire saturation_enable_bit = mac_control_word[mac_pkg::CW_MS];
   wire [39:0] product_scaled = product_shift_bit
      ? {product_ext[38:0], 1'b0} : product_ext;

   // Concatenated bus source
   wire [31:0] concat_word = {operand_bus_first, operand_bus_second};
   wire [39:0] concat_ext = {{8{concat_word[31]}}, concat_word};
   wire [39:0] concat_scaled = concat_shift
      ? {concat_ext[38:0], 1'b0} : concat_ext;

   logic [39:0] a_in;
   always_comb begin
      case (a_src_sel)
         mac_pkg::A_ZERO: a_in = 40'h00_0000_0000;
         mac_pkg::A_ROUND: a_in = mac_pkg::ROUND_CONST;
         mac_pkg::A_PRODUCT: a_in = product_scaled;
         mac_pkg::A_CONCAT: a_in = concat_scaled;
         default: a_in = 40'h00_0000_0000;
      endcase
   end

   // Accumulator as one word and the B path
   wire [7:0] acc_extension_byte = mac_status_word[7:0];
   wire [39:0] acc = {acc_extension_byte, acc_high_word,
      acc_low_word};
   // Right shift by one word keeps the sign
   wire [39:0] acc_shifted = b_shift_right
      ? {{16{acc[39]}}, acc[39:16]} : acc;
   wire [39:0] acc_inv = b_invert ? ~acc_shifted : acc_shifted;
   wire [39:0] b_in = b_use_acc ? acc_inv : 40'h00_0000_0000;
   wire carry_in = b_use_acc & b_invert;

   // 40-bit adder with carry and signed overflow
   wire [40:0] sum_wide = {1'b0, a_in} + {1'b0, b_in}
      + {40'h00_0000_0000, carry_in};
   wire [39:0] sum = sum_wide[39:0];
   wire carry_out = sum_wide[40];
   wire ovf40 = (a_in[39] == b_in[39]) & (sum[39] != a_in[39]);
   // True sign of the result, valid even past 40 bits
   wire true_neg = ovf40 ? a_in[39] : sum[39];
   wire ovf32 = (sum[39:31] != {9{sum[39]}}) | ovf40;
   wire sat_hit = saturation_enable_bit & ovf32;
   wire [39:0] acc_result = sat_hit
      ? (true_neg ? mac_pkg::SAT_NEG : mac_pkg::SAT_POS) : sum;

   // Next accumulator from either the adder or software writes
   wire acc_op = op_valid;
   wire [15:0] next_acc_high = acc_op ? acc_result[31:16]
      : (acc_high_wr ? acc_wdata : acc_high_word);
   wire [15:0] next_acc_low = acc_op ? acc_result[15:0]
      : (acc_low_wr ? acc_wdata : acc_low_word);
   wire [7:0] sw_ext = status_wr ? status_wdata[7:0] : acc_extension_byte;
   wire [7:0] next_acc_ext = acc_op ? acc_result[39:32] : sw_ext;
   wire [39:0] next_acc = {next_acc_ext, next_acc_high, next_acc_low};

   // Flags derived from the value being written
   wire acc_written = acc_op | acc_high_wr | acc_low_wr | status_wr;
   wire next_e = next_acc[39:31] != {9{next_acc[39]}};
   wire next_n = next_acc[39];
   wire next_z = next_acc == 40'h00_0000_0000;

   // Sticky flags: hardware set beats software clear
   wire sw_sl = status_wr ? status_wdata[mac_pkg::ST_SL]
      : mac_status_word[mac_pkg::ST_SL];
   wire sw_sv = status_wr ? status_wdata[mac_pkg::ST_SV]
      : mac_status_word[mac_pkg::ST_SV];
   wire next_sl = sw_sl | (acc_op & sat_hit);
   wire next_sv = sw_sv | (acc_op & ovf40);
   wire sw_c = status_wr ? status_wdata[mac_pkg::ST_C]
      : mac_status_word[mac_pkg::ST_C];
   wire next_c = acc_op ? carry_out : sw_c;

   wire [15:0] next_status = {2'b00, next_sl, next_c, next_sv,
      acc_written ? next_e : mac_status_word[mac_pkg::ST_E],
      acc_written ? next_z : mac_status_word[mac_pkg::ST_Z],
      acc_written ? next_n : mac_status_word[mac_pkg::ST_N],
      next_acc_ext};

   // Limited store reads only, never writes state
   wire flag_e = mac_status_word[mac_pkg::ST_E];
   wire flag_n = mac_status_word[mac_pkg::ST_N];
   wire [15:0] limited_acc_source = !flag_e ? acc_high_word
      : (flag_n ? mac_pkg::LIMIT_NEG : mac_pkg::LIMIT_POS);
   logic [15:0] next_store;
   always_comb begin
      case (store_sel)
         mac_pkg::ST_HIGH: next_store = acc_high_word;
         mac_pkg::ST_LOW: next_store = acc_low_word;
         mac_pkg::ST_STATUS: next_store = mac_status_word;
         mac_pkg::ST_LIMITED: next_store = limited_acc_source;
         default: next_store = acc_high_word;
      endcase
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         acc_high_word <= mac_pkg::ACC_WORD_RESET;
         acc_low_word <= mac_pkg::ACC_WORD_RESET;
         mac_status_word <= mac_pkg::STATUS_RESET;
      end else begin
         acc_high_word <= next_acc_high;
         acc_low_word <= next_acc_low;
         mac_status_word <= next_status;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         mac_control_word <= mac_pkg::CONTROL_RESET;
      end else if (control_wr) begin
         mac_control_word <= control_wdata;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         store_data <= 16'h0000;
         store_valid <= 1'b0;
      end else begin
         store_valid <= coproc_store_op;
         if (coproc_store_op) begin
            store_data <= next_store;
         end
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         table_rd_data <= 16'h0000;
      end else begin
         table_rd_data <= tbl.rd_data;
      end
   end
endmodule
`default_nettype wire
